/* design/itm_defines.svh */
`ifndef ITM_DEFINES_SVH
`define ITM_DEFINES_SVH

// Register byte offsets on the APB bus.
`define ITM_ADDR_W           8
`define ITM_OFF_TIMER_CTRL   8'h00
`define ITM_OFF_RELOAD_LOW   8'h04
`define ITM_OFF_COMPARE_LOW  8'h08
`define ITM_OFF_VALUE_LOW    8'h0c
`define ITM_OFF_VALUE_HIGH   8'h10
`define ITM_OFF_RELOAD_HIGH  8'h14
`define ITM_OFF_COMPARE_HIGH 8'h18
`define ITM_OFF_IR_CTRL      8'h1c
`define ITM_OFF_STATUS       8'h20

// Timer control field positions.
`define ITM_TC_RUN_LOW       0
`define ITM_TC_RUN_HIGH      1
`define ITM_TC_POL_B         2
`define ITM_TC_OE_B          3
`define ITM_TC_EDGE_LSB      4
`define ITM_TC_EDGE_MSB      5

// Infrared control field positions.
`define ITM_IR_BIT_SAMPLE    0
`define ITM_IR_TX_SELECT     1
`define ITM_IR_ENABLE        2

// Status field positions.
`define ITM_ST_GATE          0
`define ITM_ST_PIN_OUT       1
`define ITM_ST_RX_PIN        2

// Edge select encodings.
`define ITM_EDGE_NONE        2'h0
`define ITM_EDGE_RISE        2'h1
`define ITM_EDGE_FALL        2'h2
`define ITM_EDGE_BOTH        2'h3

// Reset values and counter limits.
`define ITM_RESET_BYTE       8'h00
`define ITM_COUNT_MAX        8'hff

`endif

/* design/itm_pkg.sv */
package itm_pkg;

	// Operating mode chosen by the infrared control bits.
	typedef enum logic [1:0] {
		ITM_MODE_ORDINARY,
		ITM_MODE_RECEIVE,
		ITM_MODE_TRANSMIT
	} itm_mode_type;

	typedef logic [7:0] itm_byte_type;

endpackage

/* design/itm_carrier_if.sv */
`timescale 1ns/10ps

// Signals between the control logic and the subcarrier timer.
interface itm_carrier_if;
	import itm_pkg::*;
	logic         run;
	logic         polarity;
	itm_byte_type reload;
	itm_byte_type compare;
	logic         load;
	itm_byte_type load_value;
	itm_byte_type value;
	logic         carrier;

	modport timer (
		input  run, polarity, reload, compare, load, load_value,
		output value, carrier
	);
	modport ctrl (
		output run, polarity, reload, compare, load, load_value,
		input  value, carrier
	);
endinterface

/* design/itm_subcarrier_timer.sv */
`timescale 1ns/10ps
`include "itm_defines.svh"

module itm_subcarrier_timer (
	// Clock and reset.
	input  wire logic   i_clk,
	input  wire logic   i_reset,
	// Link to the control logic.
	itm_carrier_if.timer bus
);
	import itm_pkg::*;

	itm_byte_type cnt_reg;
	logic         carrier_reg;

	// Up counter from the reload value to all ones; a software load wins.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt_reg <= `ITM_RESET_BYTE;
		end else if (bus.load) begin
			cnt_reg <= bus.load_value;
		end else if (bus.run) begin
			if (cnt_reg == `ITM_COUNT_MAX) begin
				cnt_reg <= bus.reload;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
			end
		end
	end

	// PWM output: active from compare to overflow, idle level set by polarity.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			carrier_reg <= 1'b0;
		end else begin
			carrier_reg <= bus.polarity ^ (bus.run & (cnt_reg >= bus.compare));
		end
	end

	assign bus.value   = cnt_reg;
	assign bus.carrier = carrier_reg;
endmodule // itm_subcarrier_timer

/* design/itm_infrared_timer_modem.sv */
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "itm_defines.svh"

module itm_infrared_timer_modem (
	// Clock and reset.
	input  wire logic                 i_clk,
	input  wire logic                 i_reset,
	// APB slave.
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic [31:0]          i_paddr,
	input  wire logic [31:0]          i_pwdata,
	input  wire logic [3:0]           i_pstrb,
	output logic      [31:0]          o_prdata,
	output logic                      o_pready,
	output logic                      o_pslverr,
	// Timer pins.
	input  wire logic                 i_timer_primary_pin,
	input  wire logic                 i_timer_count_input,
	output logic                      o_timer_output_pin_b,
	output logic                      o_timer_output_pin_b_oe,
	// Mode seen by the rest of the chip.
	output itm_pkg::itm_mode_type     o_mode
);
	import itm_pkg::*;

	itm_carrier_if sub ();

	// Software registers.
	logic         run_low_reg;
	logic         run_high_reg;
	logic         output_polarity_b_reg;
	logic         output_enable_b_reg;
	logic [1:0]   edge_select_field_reg;
	itm_byte_type reload_low_reg;
	itm_byte_type compare_low_reg;
	itm_byte_type counter_reload_high_reg;
	itm_byte_type counter_compare_high_reg;
	logic         infrared_enable_reg;
	logic         infrared_transmit_select_reg;
	logic         infrared_bit_sample_reg;
	logic         infrared_bit_sample_next;

	// Block state.
	itm_byte_type modulation_counter_high_reg;
	itm_byte_type modulation_counter_high_next;
	logic         gate_reg;
	logic         carrier_prev_reg;
	logic         count_in_prev_reg;
	logic         primary_prev_reg;
	logic         pin_out_reg;
	logic         pin_oe_reg;
	logic [31:0]  prdata_reg;
	logic         pslverr_reg;

	// Bus decode.
	logic         setup;
	logic         access;
	logic         wr;
	logic         known;
	logic [7:0]   addr;
	logic [7:0]   wbyte;

	// Mode and counter events.
	itm_mode_type mode;
	logic         count_edge;
	logic         hi_tick;
	logic         hi_ovf;
	logic         hi_match;
	logic         resync;

	// APB decode; the write takes effect at the access edge, zero wait states.
	assign setup  = i_psel & ~i_penable;
	assign access = i_psel & i_penable;
	assign addr   = i_paddr[7:0];
	assign wbyte  = i_pstrb[0] ? i_pwdata[7:0] : `ITM_RESET_BYTE;
	assign wr     = access & i_pwrite & i_pstrb[0] & known & (i_paddr[31:8] == 24'h000000);

	always_comb begin
		unique case (addr)
			`ITM_OFF_TIMER_CTRL, `ITM_OFF_RELOAD_LOW, `ITM_OFF_COMPARE_LOW,
			`ITM_OFF_VALUE_LOW, `ITM_OFF_VALUE_HIGH, `ITM_OFF_RELOAD_HIGH,
			`ITM_OFF_COMPARE_HIGH, `ITM_OFF_IR_CTRL, `ITM_OFF_STATUS: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// Mode decode from enable and transmit select.
	always_comb begin
		if (!infrared_enable_reg) begin
			mode = ITM_MODE_ORDINARY;
		end else if (infrared_transmit_select_reg) begin
			mode = ITM_MODE_TRANSMIT;
		end else begin
			mode = ITM_MODE_RECEIVE;
		end
	end
	assign o_mode = mode;

	// Timer control register.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			run_low_reg           <= 1'b0;
			run_high_reg          <= 1'b0;
			output_polarity_b_reg <= 1'b0;
			output_enable_b_reg   <= 1'b0;
			edge_select_field_reg <= `ITM_EDGE_NONE;
		end else if (wr && addr == `ITM_OFF_TIMER_CTRL) begin
			run_low_reg           <= wbyte[`ITM_TC_RUN_LOW];
			run_high_reg          <= wbyte[`ITM_TC_RUN_HIGH];
			output_polarity_b_reg <= wbyte[`ITM_TC_POL_B];
			output_enable_b_reg   <= wbyte[`ITM_TC_OE_B];
			edge_select_field_reg <= wbyte[`ITM_TC_EDGE_MSB:`ITM_TC_EDGE_LSB];
		end
	end

	// Reload and compare registers of both halves.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			reload_low_reg           <= `ITM_RESET_BYTE;
			compare_low_reg          <= `ITM_RESET_BYTE;
			counter_reload_high_reg  <= `ITM_RESET_BYTE;
			counter_compare_high_reg <= `ITM_RESET_BYTE;
		end else if (wr) begin
			if (addr == `ITM_OFF_RELOAD_LOW) begin
				reload_low_reg <= wbyte;
			end
			if (addr == `ITM_OFF_COMPARE_LOW) begin
				compare_low_reg <= wbyte;
			end
			if (addr == `ITM_OFF_RELOAD_HIGH) begin
				counter_reload_high_reg <= wbyte;
			end
			if (addr == `ITM_OFF_COMPARE_HIGH) begin
				counter_compare_high_reg <= wbyte;
			end
		end
	end

	// Infrared enable and transmit select bits.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			infrared_enable_reg          <= 1'b0;
			infrared_transmit_select_reg <= 1'b0;
		end else if (wr && addr == `ITM_OFF_IR_CTRL) begin
			infrared_enable_reg          <= wbyte[`ITM_IR_ENABLE];
			infrared_transmit_select_reg <= wbyte[`ITM_IR_TX_SELECT];
		end
	end

	// Subcarrier timer drive; the low timer is the only carrier source.
	// Subcarrier from low timer.
	assign sub.run        = run_low_reg;
	assign sub.reload     = reload_low_reg;
	assign sub.compare    = compare_low_reg;
	assign sub.load       = wr && addr == `ITM_OFF_VALUE_LOW;
	assign sub.load_value = wbyte;
	assign sub.polarity   = output_polarity_b_reg;

	itm_subcarrier_timer u_subcarrier (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.bus     (sub.timer)
	);

	// Previous pin and carrier levels for edge detection.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			carrier_prev_reg  <= 1'b0;
			count_in_prev_reg <= 1'b0;
			primary_prev_reg  <= 1'b0;
		end else begin
			carrier_prev_reg  <= sub.carrier;
			count_in_prev_reg <= i_timer_count_input;
			primary_prev_reg  <= i_timer_primary_pin;
		end
	end

	// Edge picked by the edge select field.
	function automatic logic edge_hit(input logic [1:0] sel, input logic now,
		input logic prev);
		edge_hit = ((sel == `ITM_EDGE_RISE || sel == `ITM_EDGE_BOTH) && now && !prev) ||
			((sel == `ITM_EDGE_FALL || sel == `ITM_EDGE_BOTH) && !now && prev);
	endfunction

	// Count source for the high counter.
	always_comb begin
		if (mode == ITM_MODE_ORDINARY) begin
			count_edge = edge_hit(edge_select_field_reg, i_timer_count_input,
				count_in_prev_reg);
		end else if (output_polarity_b_reg) begin
			count_edge = sub.carrier && !carrier_prev_reg;
		end else begin
			count_edge = !sub.carrier && carrier_prev_reg;
		end
	end

	assign hi_tick = run_high_reg & count_edge;
	assign hi_ovf  = hi_tick && modulation_counter_high_reg == `ITM_COUNT_MAX;
	assign resync  = mode == ITM_MODE_RECEIVE &&
		edge_hit(edge_select_field_reg, i_timer_primary_pin, primary_prev_reg);

	// Next value of the high counter.
	always_comb begin
		modulation_counter_high_next = modulation_counter_high_reg;
		if (wr && addr == `ITM_OFF_VALUE_HIGH) begin
			modulation_counter_high_next = wbyte;
		end else if (resync) begin
			modulation_counter_high_next = counter_reload_high_reg;
		end else if (hi_ovf) begin
			modulation_counter_high_next = counter_reload_high_reg;
		end else if (hi_tick) begin
			modulation_counter_high_next = modulation_counter_high_reg + 8'h01;
		end
	end

	// A match is the count arriving at the compare value.
	// Compare match detection.
	assign hi_match = (hi_tick || resync) && !(wr && addr == `ITM_OFF_VALUE_HIGH) &&
		modulation_counter_high_next == counter_compare_high_reg;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			modulation_counter_high_reg <= `ITM_RESET_BYTE;
		end else begin
			modulation_counter_high_reg <= modulation_counter_high_next;
		end
	end

	// Bit sample: storage bit, or pin capture in receive; capture beats a write.
	always_comb begin
		infrared_bit_sample_next = infrared_bit_sample_reg;
		if (wr && addr == `ITM_OFF_IR_CTRL) begin
			infrared_bit_sample_next = wbyte[`ITM_IR_BIT_SAMPLE];
		end
		if (mode == ITM_MODE_RECEIVE && hi_match) begin
			infrared_bit_sample_next = i_timer_primary_pin;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			infrared_bit_sample_reg <= 1'b0;
		end else begin
			infrared_bit_sample_reg <= infrared_bit_sample_next;
		end
	end

	// Gate follows the sample bit only at a high overflow in transmit.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			gate_reg <= 1'b0;
		end else if (mode != ITM_MODE_TRANSMIT) begin
			gate_reg <= 1'b0;
		end else if (hi_ovf) begin
			gate_reg <= infrared_bit_sample_reg;
		end
	end

	// Output pin B: gated carrier in transmit, ordinary PWM otherwise.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_out_reg <= 1'b0;
			pin_oe_reg  <= 1'b0;
		end else if (mode == ITM_MODE_TRANSMIT) begin
			pin_out_reg <= gate_reg ? sub.carrier : output_polarity_b_reg;
			pin_oe_reg  <= 1'b1;
		end else begin
			pin_out_reg <= sub.carrier;
			pin_oe_reg  <= output_enable_b_reg;
		end
	end

	assign o_timer_output_pin_b    = pin_out_reg;
	assign o_timer_output_pin_b_oe = pin_oe_reg;

	// Read data is captured in the setup phase and shown in the access phase.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pslverr_reg <= !known || i_paddr[31:8] != 24'h000000;
			prdata_reg  <= 32'h00000000;
			unique case (addr)
				`ITM_OFF_TIMER_CTRL: prdata_reg[5:0] <= {edge_select_field_reg,
					output_enable_b_reg, output_polarity_b_reg, run_high_reg,
					run_low_reg};
				`ITM_OFF_RELOAD_LOW:   prdata_reg[7:0] <= reload_low_reg;
				`ITM_OFF_COMPARE_LOW:  prdata_reg[7:0] <= compare_low_reg;
				`ITM_OFF_VALUE_LOW:    prdata_reg[7:0] <= sub.value;
				`ITM_OFF_VALUE_HIGH:   prdata_reg[7:0] <= modulation_counter_high_reg;
				`ITM_OFF_RELOAD_HIGH:  prdata_reg[7:0] <= counter_reload_high_reg;
				`ITM_OFF_COMPARE_HIGH: prdata_reg[7:0] <= counter_compare_high_reg;
				`ITM_OFF_IR_CTRL: prdata_reg[2:0] <= {infrared_enable_reg,
					infrared_transmit_select_reg, infrared_bit_sample_reg};
				`ITM_OFF_STATUS: prdata_reg[2:0] <= {i_timer_primary_pin,
					pin_out_reg, gate_reg};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign o_prdata  = prdata_reg;
	assign o_pready  = 1'b1;
	assign o_pslverr = pslverr_reg & access;
endmodule // itm_infrared_timer_modem

/* verif/itm_assertions.sv */
`timescale 1ns/10ps
`include "itm_defines.svh"

// Watches the top ports and shadows the control bits that software writes.
module itm_checker (
	// Clock and reset.
	input wire logic                  i_clk,
	input wire logic                  i_reset,
	// APB side.
	input wire logic                  i_psel,
	input wire logic                  i_penable,
	input wire logic                  i_pwrite,
	input wire logic [31:0]           i_paddr,
	input wire logic [31:0]           i_pwdata,
	input wire logic [3:0]            i_pstrb,
	input wire logic [31:0]           o_prdata,
	input wire logic                  o_pready,
	input wire logic                  o_pslverr,
	// Pins and mode.
	input wire logic                  i_timer_primary_pin,
	input wire logic                  i_timer_count_input,
	input wire logic                  o_timer_output_pin_b,
	input wire logic                  o_timer_output_pin_b_oe,
	input wire itm_pkg::itm_mode_type o_mode
);
	import itm_pkg::*;
	logic       wr, rd, acc, mapped, tx, seen_reg, pol_reg, oeb_reg;
	logic [2:0] ir_reg;
	itm_mode_type exp_mode;

	// Decodes accesses and the mode that the shadow bits call for.
	assign acc = i_psel & i_penable;
	assign wr = acc & i_pwrite & i_pstrb[0] & (i_paddr[31:8] == 24'h0);
	assign rd = acc & ~i_pwrite;
	assign mapped = (i_paddr[31:8] == 24'h0) && (i_paddr[1:0] == 2'h0) && (i_paddr[7:0] <= 8'h20);
	assign tx = (o_mode == ITM_MODE_TRANSMIT);
	assign exp_mode = !ir_reg[2] ? ITM_MODE_ORDINARY :
		(ir_reg[1] ? ITM_MODE_TRANSMIT : ITM_MODE_RECEIVE);

	// Shadows infrared control and the polarity and enable bits.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ir_reg <= 3'h0;
			pol_reg <= 1'b0;
			oeb_reg <= 1'b0;
		end else if (wr && i_paddr[7:0] == `ITM_OFF_IR_CTRL) begin
			ir_reg <= i_pwdata[2:0];
		end else if (wr && i_paddr[7:0] == `ITM_OFF_TIMER_CTRL) begin
			pol_reg <= i_pwdata[2];
			oeb_reg <= i_pwdata[3];
		end
	end

	// Remembers whether the sample bit was set during this transmit stay.
	always_ff @(posedge i_clk) begin
		if (i_reset || !tx) begin
			seen_reg <= 1'b0;
		end else if (ir_reg[0]) begin
			seen_reg <= 1'b1;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);

	ready_high_a: assert property (o_pready) else $error("pready low");
	err_decode_a: assert property (acc |-> o_pslverr == !mapped) else $error("pslverr wrong");
	err_zero_a: assert property (rd && !mapped |-> o_prdata == 32'h0) else $error("bad read data");
	ir_reserved_a: assert property (
		rd && i_paddr == 32'h1c |-> o_prdata[31:3] == 29'h0) else $error("reserved set");
	ir_hold_a: assert property (
		rd && i_paddr == 32'h1c && $past(o_mode) != ITM_MODE_RECEIVE
		&& $past(o_mode, 2) != ITM_MODE_RECEIVE |-> o_prdata[2:0] == $past(ir_reg))
		else $error("control read wrong");
	mode_map_a: assert property (o_mode == exp_mode) else $error("mode wrong");
	tx_drive_a: assert property (
		tx |=> o_timer_output_pin_b_oe) else $error("pin not driven");
	plain_oe_a: assert property (
		!tx |=> o_timer_output_pin_b_oe == $past(oeb_reg)) else $error("oe wrong");
	tx_idle_a: assert property (
		tx && !seen_reg && !ir_reg[0] |=> o_timer_output_pin_b == $past(pol_reg))
		else $error("pin not idle");
endmodule // itm_checker

bind itm_infrared_timer_modem itm_checker itm_checker_inst (
	.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_timer_primary_pin(i_timer_primary_pin), .i_timer_count_input(i_timer_count_input),
	.o_timer_output_pin_b(o_timer_output_pin_b),
	.o_timer_output_pin_b_oe(o_timer_output_pin_b_oe), .o_mode(o_mode));

/* verif/itm_ir_partner.sv */
`timescale 1ns/10ps

// Infrared emitter and receiver module at the pins.
module itm_ir_partner (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// Emitter side.
	input  wire logic        i_pin_b,
	input  wire logic        i_pin_b_oe,
	output logic      [15:0] o_pulses,
	// Receiver side.
	input  wire logic        i_level,
	output logic             o_rx_pin
);
	logic prev_reg;

	// Counts light pulses, only while the pin is driven.
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prev_reg <= 1'b0;
			o_pulses <= 16'h0;
		end else begin
			prev_reg <= i_pin_b;
			if (i_pin_b_oe && i_pin_b && !prev_reg) begin
				o_pulses <= o_pulses + 16'h1;
			end
		end
	end

	// Filtered carrier presence, one clock behind the light.
	always_ff @(posedge i_clk) begin
		o_rx_pin <= i_level;
	end
endmodule // itm_ir_partner

/* verif/itm_testbench.sv */
`timescale 1ns/10ps
`include "itm_defines.svh"

module testbench;
	import itm_pkg::*;
	logic         clk, rst, psel, pen, pwr, cnt_in, level, pready, pslverr, pin_b, pin_oe;
	logic         rx_pin, err, m;
	logic [31:0]  paddr, pwdata, prdata, rdata, v;
	logic [3:0]   pstrb;
	logic [15:0]  pulses, p0;
	itm_mode_type mode;
	int           mismatches, num_checks, cnt;

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	itm_infrared_timer_modem itm_infrared_timer_modem_inst (
		.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_timer_primary_pin(rx_pin),
		.i_timer_count_input(cnt_in), .o_timer_output_pin_b(pin_b),
		.o_timer_output_pin_b_oe(pin_oe), .o_mode(mode));

	itm_ir_partner itm_ir_partner_inst (
		.i_clk(clk), .i_reset(rst), .i_pin_b(pin_b), .i_pin_b_oe(pin_oe),
		.o_pulses(pulses), .i_level(level), .o_rx_pin(rx_pin));

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Compares one value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the wait for pready is bounded.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			complete_run();
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask

	// Counts light pulses over a window of 32 clocks.
	task automatic pulses_in(input logic [31:0] e);
		repeat (40) @(posedge clk);
		p0 = pulses;
		repeat (32) @(posedge clk);
		chk(32'(pulses - p0), e);
	endtask

	// Mode that a control value selects.
	function automatic itm_mode_type mode_of(input logic [2:0] c);
		if (!c[2]) begin
			return ITM_MODE_ORDINARY;
		end
		return c[1] ? ITM_MODE_TRANSMIT : ITM_MODE_RECEIVE;
	endfunction

	initial begin
		{rst, psel, pen, pwr, cnt_in, level} = 6'h20;
		{paddr, pwdata} = 64'h0;
		pstrb = 4'hf;
		mismatches = 0;
		num_checks = 0;
		void'($urandom(32'h3e5a623b));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Every register resets to zero; the unmapped place is refused.
		for (int a = 0; a <= 36; a += 4) begin
			rd(8'(a), 32'h0);
			chk(32'(err), 32'(a == 36));
		end
		// Ordinary counting of count input edges on a random edge choice, select without enable.
		cnt = $urandom_range(8, 1);
		v = $urandom_range(3, 1);
		apb(1'b1, `ITM_OFF_IR_CTRL, 32'h02);
		apb(1'b1, `ITM_OFF_TIMER_CTRL, {26'h0, v[1:0], 4'h2});
		apb(1'b1, `ITM_OFF_VALUE_HIGH, 32'h10);
		repeat (cnt) begin
			repeat (2) @(posedge clk);
			cnt_in <= 1'b1;
			repeat (2) @(posedge clk);
			cnt_in <= 1'b0;
		end
		repeat (2) @(posedge clk);
		rd(`ITM_OFF_VALUE_HIGH, 32'h10 + cnt * ((v[1:0] == 2'h3) ? 2 : 1));
		// Random control values: mode and read-back.
		repeat (8) begin
			v = $urandom;
			apb(1'b1, `ITM_OFF_IR_CTRL, v);
			@(negedge clk);
			chk(32'(mode), 32'(mode_of(v[2:0])));
			m = (v[2:1] == 2'b10);
			apb(1'b0, `ITM_OFF_IR_CTRL, 32'h0);
			chk(rdata | 32'(m), {29'h0, v[2:0]} | 32'(m));
		end
		// A write without its low strobe leaves the register alone.
		apb(1'b1, `ITM_OFF_IR_CTRL, 32'h0);
		pstrb <= 4'he;
		apb(1'b1, `ITM_OFF_IR_CTRL, 32'h03);
		pstrb <= 4'hf;
		rd(`ITM_OFF_IR_CTRL, 32'h0);
		// Subcarrier of four clocks, intervals of four subcarrier cycles.
		apb(1'b1, `ITM_OFF_RELOAD_LOW, 32'hfc);
		apb(1'b1, `ITM_OFF_COMPARE_LOW, 32'hfe);
		apb(1'b1, `ITM_OFF_RELOAD_HIGH, 32'hfc);
		apb(1'b1, `ITM_OFF_COMPARE_HIGH, 32'hfd);
		// Both counters start near the top, so the first overflow comes within a few clocks.
		apb(1'b1, `ITM_OFF_VALUE_LOW, 32'hfc);
		apb(1'b1, `ITM_OFF_VALUE_HIGH, 32'hfc);
		apb(1'b1, `ITM_OFF_TIMER_CTRL, 32'h07);
		apb(1'b1, `ITM_OFF_IR_CTRL, 32'h06);
		pulses_in(32'h0);
		@(negedge clk);
		chk({30'h0, pin_oe, pin_b}, 32'h3);
		apb(1'b1, `ITM_OFF_IR_CTRL, 32'h07);
		pulses_in(32'h8);
		// The high counter only runs from its reload to the top.
		repeat (4) begin
			apb(1'b0, `ITM_OFF_VALUE_HIGH, 32'h0);
			chk({rdata[31:2], 2'h0}, 32'hfc);
		end
		// Receive: each match captures the pin, the next one overwrites it.
		level <= 1'($urandom);
		repeat (2) begin
			apb(1'b1, `ITM_OFF_IR_CTRL, 32'h04);
			repeat (64) @(posedge clk);
			rd(`ITM_OFF_IR_CTRL, {29'h2, level});
			level <= ~level;
		end
		complete_run();
	end
endmodule // testbench
